// [rtl/pwm_override_pkg.sv]
// Register map, field positions and reset values of the PWM output stage.
package pwm_override_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [3:0] SOFT_CTRL_OFS = 4'h0;
  localparam logic [3:0] MODE_OFS = 4'h4;
  localparam logic [3:0] OE_OFS = 4'h8;
  localparam logic [3:0] TCTRL_OFS = 4'hC;
  // Software output control fields.
  localparam int W_LEVEL_BIT = 0;
  localparam int V_LEVEL_BIT = 1;
  localparam int U_LEVEL_BIT = 2;
  localparam int SOFT_SEL_BIT = 7;
  // Output mode fields.
  localparam int ACTIVE_LEVEL_BIT = 7;
  localparam int U_POL_BIT = 6;
  localparam int V_POL_BIT = 5;
  localparam int W_POL_BIT = 4;
  // Output enable and timer control fields.
  localparam int PIN_OE_BIT = 0;
  localparam int COUNT_EN_BIT = 15;
  // Reset values.
  localparam logic [7:0] SOFT_CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [5:0] OE_RST = 6'h00;
  localparam logic [15:0] TCTRL_RST = 16'h0000;
  // Dead-time width in base clock cycles.
  localparam logic [7:0] DEAD_TIME_RST = 8'h00;
endpackage : pwm_override_pkg

// [rtl/pwm_software_output_override.sv]
// PWM output stage with software level override, polarity and dead time.
// Summary of operation
// [R1] Bit 0 sets W levels; W level 0 drives negative W inverted active level.
// [R2] Positive W follows its polarity bit relative to active level and W level.
// [R3] W level changes under software output pass through the dead-time stage.
// [R4] Active level at mode bit 7, U polarity bit 6, V polarity bit 5.
// [R5] Pins come from timer flip-flops or software levels; software wins.
// [R6] After deselect with counting on, software levels hold until first match.
// [R7] Deselect with U level 1: flop holds 1, reset by down-count match.
// [R8] Deselect with U level 0: flop holds 0, set by up-count match.
// [R9] Deselect while counting disabled stops driving all six outputs.
// [R10] Select with U level 0 while running: flop reset at the first clock edge with select set, without waiting for a match.
// [R11] Pin is high impedance unless enabled and software or counting is on.
// [R12] OE bit 0, select bit 7, U level bit 2, count enable bit 15.
// [R13] Bit 1 sets V levels from active level and V polarity bit.
// [R14] U level changes under software output pass through the dead-time stage.
// [R15] Negative W with W level 1 is complement of its level-0 value.
// [R16] Control bits and output flops clear on reset; outputs start disabled.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pwm_software_output_override #(
  parameter int DT_W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Compare events from the timer core, one per phase, one-cycle pulses.
  input wire logic [2:0] match_up_i,
  input wire logic [2:0] match_down_i,
  input wire logic [DT_W-1:0] dead_time_i,
  // Pulse outputs: u_neg, u_pos, v_neg, v_pos, w_neg, w_pos.
  output logic [5:0] pulse_o,
  output logic [5:0] pulse_oe_o,
  // Count enable seen by the timer core.
  output logic count_enable_o
);
  import pwm_override_pkg::*;

  logic [7:0] soft_ctrl;
  logic [7:0] out_mode;
  logic [5:0] out_en;
  logic [15:0] tctrl;
  logic [2:0] ff;
  logic [2:0] pend;
  logic drive;
  logic ack_q;
  logic [31:0] rdata;
  logic [5:0] raw;
  logic [5:0] dt_out;

  wire soft_sel = soft_ctrl[SOFT_SEL_BIT];
  wire count_en = tctrl[COUNT_EN_BIT];
  wire active_lvl = out_mode[ACTIVE_LEVEL_BIT];
  wire [2:0] soft_lvl = {soft_ctrl[W_LEVEL_BIT], soft_ctrl[V_LEVEL_BIT],
                         soft_ctrl[U_LEVEL_BIT]};
  wire [2:0] pos_pol = {out_mode[W_POL_BIT], out_mode[V_POL_BIT],
                        out_mode[U_POL_BIT]};
  wire req = cyc_i && stb_i && !ack_q;
  wire wr = req && we_i;
  wire wr_soft = wr && adr_i == SOFT_CTRL_OFS && sel_i[0];
  wire wr_mode = wr && adr_i == MODE_OFS && sel_i[0];
  wire wr_oe = wr && adr_i == OE_OFS && sel_i[0];
  wire wr_tc_lo = wr && adr_i == TCTRL_OFS && sel_i[0];
  wire wr_tc_hi = wr && adr_i == TCTRL_OFS && sel_i[1];
  wire [7:0] next_soft = wr_soft ? dat_i[7:0] : soft_ctrl;
  wire next_sel = next_soft[SOFT_SEL_BIT];
  wire next_cnt = wr_tc_hi ? dat_i[COUNT_EN_BIT] : count_en;

  assign rdata = (adr_i == SOFT_CTRL_OFS) ? {24'h000000, soft_ctrl} :
                 (adr_i == MODE_OFS) ? {24'h000000, out_mode} :
                 (adr_i == OE_OFS) ? {26'h0000000, out_en} :
                 (adr_i == TCTRL_OFS) ? {16'h0000, tctrl} : 32'h00000000;
  assign ack_o = ack_q;
  assign count_enable_o = count_en;

  // Register file; every write is acked one cycle after the request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      soft_ctrl <= SOFT_CTRL_RST; // [R16]
      out_mode <= MODE_RST;
      out_en <= OE_RST;
      tctrl <= TCTRL_RST;
      ack_q <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      if (req)
        dat_o <= rdata;
      soft_ctrl <= next_soft; // [R12]
      if (wr_mode)
        out_mode <= dat_i[7:0]; // [R4]
      if (wr_oe)
        out_en <= dat_i[5:0];
      if (wr_tc_lo)
        tctrl[7:0] <= dat_i[7:0];
      if (wr_tc_hi)
        tctrl[15:8] <= dat_i[15:8];
    end
  end

  // Flop per phase: software selection loads it, compare matches move it.
  // While pend is set the pins keep the software level awaiting a match.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ff <= 3'h0; // [R16]
      pend <= 3'h0;
      drive <= 1'b0;
    end
    else
    begin
      if (next_sel)
        drive <= 1'b1;
      else if (!next_cnt && !(|pend))
        drive <= 1'b0; // [R9]
      else if (next_cnt)
        drive <= 1'b1;
      if (soft_sel && !next_sel && !count_en)
        drive <= 1'b0; // [R9]
      for (int i = 0; i < 3; i++)
      begin
        if (soft_sel)
        begin
          ff[i] <= soft_lvl[i]; // [R5] [R10]
          pend[i] <= 1'b0;
          if (!next_sel && count_en)
            pend[i] <= 1'b1; // [R6]
        end
        else if (match_down_i[i])
        begin
          ff[i] <= 1'b0; // [R7]
          pend[i] <= 1'b0;
        end
        else if (match_up_i[i])
        begin
          ff[i] <= 1'b1; // [R8]
          pend[i] <= 1'b0;
        end
      end
    end
  end

  // Level per phase: software level takes priority over the flop.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_phase
      wire lvl = soft_sel ? soft_lvl[g] : ff[g]; // [R5] [R6]
      // Negative pin: level 0 gives inverted active level.
      assign raw[2*g] = lvl ? active_lvl : ~active_lvl; // [R1] [R13] [R15]
      // Positive pin: polarity 0 gives active level when the level is 0.
      assign raw[2*g+1] = (lvl ^ pos_pol[g]) ? ~active_lvl
                                              : active_lvl; // [R2] [R13]
    end
  endgenerate

  // Dead-time stage: a rising edge of each pin waits out the dead time,
  // falling edges pass at once, so with active level 1 and polarity 0 a pair never overlaps its active phases.
  generate
    for (g = 0; g < 6; g++)
    begin : g_dt
      logic [DT_W-1:0] cnt;
      logic q;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          cnt <= '0;
          q <= 1'b0;
        end
        else if (raw[g] == q)
          cnt <= '0;
        else if (!raw[g] || cnt >= dead_time_i)
        begin
          q <= raw[g]; // [R3] [R14]
          cnt <= '0;
        end
        else
          cnt <= cnt + 1'b1;
      end
      assign dt_out[g] = q;
    end
  endgenerate

  assign pulse_o = dt_out;
  assign pulse_oe_o = out_en & {6{drive & (soft_sel | count_en)}}; // [R11]

  property p_sel_drive;
    @(posedge clk_i) disable iff (rst_i)
      soft_sel |-> pulse_oe_o == out_en;
  endproperty
  a_sel_drive: assert property (p_sel_drive); // [R11]

  property p_oe_off;
    @(posedge clk_i) disable iff (rst_i)
      !out_en[PIN_OE_BIT] |-> !pulse_oe_o[0];
  endproperty
  a_oe_off: assert property (p_oe_off); // [R11]

  property p_stop;
    @(posedge clk_i) disable iff (rst_i)
      (!soft_sel && !count_en) |-> pulse_oe_o == 6'h00;
  endproperty
  a_stop: assert property (p_stop); // [R9]

  sequence s_down;
    !soft_sel && match_down_i[0];
  endsequence
  property p_down;
    @(posedge clk_i) disable iff (rst_i) s_down |=> !ff[0];
  endproperty
  a_down: assert property (p_down); // [R7]

  sequence s_up;
    !soft_sel && !match_down_i[0] && match_up_i[0];
  endsequence
  property p_up;
    @(posedge clk_i) disable iff (rst_i) s_up |=> ff[0];
  endproperty
  a_up: assert property (p_up); // [R8]

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
      soft_sel |=> ff[0] == $past(soft_lvl[0]);
  endproperty
  a_load: assert property (p_load); // [R5]

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!soft_sel && !match_up_i[0] && !match_down_i[0]) |=> $stable(ff[0]);
  endproperty
  a_hold: assert property (p_hold); // [R6]

  property p_fall;
    @(posedge clk_i) disable iff (rst_i)
      (!raw[0] && dt_out[0]) |=> !dt_out[0];
  endproperty
  a_fall: assert property (p_fall); // [R14]

  property p_ack;
    @(posedge clk_i) disable iff (rst_i) req |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack); // [R12]

  // The pair checks look at the levels before dead time, where the
  // polarity rules are exact; the dead-time stage only delays rises.
  property p_pair_w;
    @(posedge clk_i) disable iff (rst_i)
      raw[5] == (raw[4] ^ !pos_pol[2]);
  endproperty
  a_pair_w: assert property (p_pair_w); // [R2]

  property p_pair_v;
    @(posedge clk_i) disable iff (rst_i)
      raw[3] == (raw[2] ^ !pos_pol[1]);
  endproperty
  a_pair_v: assert property (p_pair_v); // [R13]

  property p_w_neg;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && !soft_lvl[2]) |-> raw[4] == !active_lvl;
  endproperty
  a_w_neg: assert property (p_w_neg); // [R1]

  property p_v_neg;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && !soft_lvl[1]) |-> raw[2] == !active_lvl;
  endproperty
  a_v_neg: assert property (p_v_neg); // [R13]

  property p_w_flip;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && $stable(soft_sel) && $stable(active_lvl) &&
       $changed(soft_lvl[2])) |-> $changed(raw[4]);
  endproperty
  a_w_flip: assert property (p_w_flip); // [R15]

  sequence s_w_low;
    !raw[4];
  endsequence
  sequence s_w_rise;
    raw[4] && dead_time_i != '0;
  endsequence
  property p_w_dead;
    @(posedge clk_i) disable iff (rst_i)
      s_w_low ##1 s_w_rise |=> !dt_out[4];
  endproperty
  a_w_dead: assert property (p_w_dead); // [R3]

  sequence s_u_low;
    !raw[0];
  endsequence
  sequence s_u_rise;
    raw[0] && dead_time_i != '0;
  endsequence
  property p_u_dead;
    @(posedge clk_i) disable iff (rst_i)
      s_u_low ##1 s_u_rise |=> !dt_out[0];
  endproperty
  a_u_dead: assert property (p_u_dead); // [R14]

  property p_pend_hold;
    @(posedge clk_i) disable iff (rst_i)
      (pend[0] && !soft_sel && !match_up_i[0] && !match_down_i[0])
        |=> pend[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold); // [R6]

  property p_desel_pend;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && !next_sel && count_en) |=> pend == 3'h7;
  endproperty
  a_desel_pend: assert property (p_desel_pend); // [R6]

  property p_count_out;
    @(posedge clk_i) disable iff (rst_i)
      (!soft_sel && count_en) |-> pulse_oe_o == out_en;
  endproperty
  a_count_out: assert property (p_count_out); // [R11]

  property p_sw_u;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && soft_lvl[0] && active_lvl) |-> raw[0];
  endproperty
  a_sw_u: assert property (p_sw_u); // [R11]

  property p_desel_stop;
    @(posedge clk_i) disable iff (rst_i)
      (soft_sel && !next_sel && !next_cnt) |=> pulse_oe_o == 6'h00;
  endproperty
  a_desel_stop: assert property (p_desel_stop); // [R9]

  property p_rst_clear;
    @(posedge clk_i)
      rst_i |=> (soft_ctrl == SOFT_CTRL_RST && ff == 3'h0 &&
        pulse_oe_o == 6'h00);
  endproperty
  a_rst_clear: assert property (p_rst_clear); // [R16]
endmodule : pwm_software_output_override
`default_nettype wire

// [bench/gate_driver_model.sv]
// Behavioural model of the external gate drivers on the six pulse pins.
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model (
  // Pulse outputs and their drive enables.
  input wire logic [5:0] pulse_i,
  input wire logic [5:0] oe_i,
  // Levels seen at the driver inputs.
  output logic [5:0] pin_o
);
  // Driver inputs carry pull-downs, so an undriven pin reads low.
  assign pin_o = pulse_i & oe_i;
endmodule : gate_driver_model
`default_nettype wire

// [bench/pwm_software_output_override_tb_top.sv]
// Self-checking bench for the PWM software output stage.
`timescale 1ns/1ns
`default_nettype none
module pwm_software_output_override_tb_top;
  import pwm_override_pkg::*;
  logic clk_i, rst_i, cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o, q;
  logic ack_o, count_enable_o;
  logic [2:0] mu, md, lv, pol;
  logic [7:0] dt;
  logic a;
  logic [5:0] pulse_o, pulse_oe_o, pin;
  int bad_count, samples_checked;
  pwm_software_output_override dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .match_up_i(mu),
    .match_down_i(md), .dead_time_i(dt), .pulse_o(pulse_o),
    .pulse_oe_o(pulse_oe_o), .count_enable_o(count_enable_o));
  gate_driver_model drv (.pulse_i(pulse_o), .oe_i(pulse_oe_o), .pin_o(pin));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  // Waits for ack without assuming a latency; the watchdog bounds hangs.
  task wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task settle;
    repeat (12) @(posedge clk_i);
  endtask : settle
  function logic [5:0] exp_pins(logic [2:0] l, logic act, logic [2:0] p);
    return {act ^ l[0] ^ p[0], ~(act ^ l[0]), act ^ l[1] ^ p[1],
      ~(act ^ l[1]), act ^ l[2] ^ p[2], ~(act ^ l[2])};
  endfunction : exp_pins
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
  initial
  begin
    {cyc, stb, we, adr, dat, mu, md, dt} = '0;
    sel = 4'hF;
    rst_i = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'hB041));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, SOFT_CTRL_OFS, 32'h0);
    chk("soft_rst", 32'h0, q);
    wb(1'b0, MODE_OFS, 32'h0);
    chk("mode_rst", 32'h0, q);
    wb(1'b0, TCTRL_OFS, 32'h0);
    chk("tctrl_rst", 32'h0, q);
    chk("oe_rst", 32'h0, {26'h0, pulse_oe_o});
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, OE_OFS, 32'h3F);
    repeat (24)
    begin
      {lv, pol, a} = 7'($urandom);
      dt <= 8'($urandom % 4);
      wb(1'b1, MODE_OFS, {24'h0, a, pol[2], pol[1], pol[0], 4'h0});
      wb(1'b1, SOFT_CTRL_OFS, {24'h0, 1'b1, 4'h0, lv});
      @(posedge clk_i);
      mu <= 3'($urandom);
      md <= 3'($urandom);
      @(posedge clk_i);
      {mu, md} <= '0;
      settle();
      chk("pins", {26'h0, exp_pins(lv, a, pol)},
        {26'h0, pin});
      chk("oe", 32'h3F, {26'h0, pulse_oe_o});
      wb(1'b0, SOFT_CTRL_OFS, 32'h0);
      chk("soft_rd", {24'h0, 1'b1, 4'h0, lv}, q);
    end
    wb(1'b1, SOFT_CTRL_OFS, 32'h04);
    settle();
    chk("off_oe", 32'h0, {26'h0, pulse_oe_o});
    wb(1'b1, MODE_OFS, 32'h80);
    wb(1'b1, TCTRL_OFS, 32'h8000);
    chk("cnt_en", 32'h1, {31'h0, count_enable_o});
    wb(1'b1, SOFT_CTRL_OFS, 32'h84);
    settle();
    chk("u_neg_soft", 32'h1, {31'h0, pin[0]});
    wb(1'b1, SOFT_CTRL_OFS, 32'h04);
    settle();
    chk("u_neg_hold", 32'h1, {31'h0, pin[0]});
    chk("oe_timer", 32'h3F, {26'h0, pulse_oe_o});
    @(posedge clk_i);
    md <= 3'h1;
    @(posedge clk_i);
    md <= 3'h0;
    settle();
    chk("u_neg_match", 32'h0, {31'h0, pin[0]});
    dt <= 8'h03;
    wb(1'b1, SOFT_CTRL_OFS, 32'h84);
    chk("dt_wait", 32'h0, {31'h0, pin[0]});
    repeat (2) @(posedge clk_i);
    chk("dt_mid", 32'h0, {31'h0, pin[0]});
    settle();
    chk("dt_done", 32'h1, {31'h0, pin[0]});
    wb(1'b1, SOFT_CTRL_OFS, 32'h80);
    settle();
    chk("u_sel_low", 32'h0, {31'h0, pin[0]});
    wb(1'b1, SOFT_CTRL_OFS, 32'h00);
    settle();
    chk("u_hold_low", 32'h0, {31'h0, pin[0]});
    chk("oe_hold", 32'h3F, {26'h0, pulse_oe_o});
    @(posedge clk_i);
    mu <= 3'h1;
    @(posedge clk_i);
    mu <= 3'h0;
    settle();
    chk("u_neg_set", 32'h1, {31'h0, pin[0]});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OE_OFS, 32'h0);
    chk("oe_reg_rst", 32'h0, q);
    chk("oe_pins_rst", 32'h0, {26'h0, pulse_oe_o});
    chk("cnt_rst", 32'h0, {31'h0, count_enable_o});
    summarize();
  end
endmodule : pwm_software_output_override_tb_top
`default_nettype wire
